// ==== src/dgd_defines.svh ====
// register indices, field positions, reset values and arithmetic constants
`ifndef DGD_DEFINES_SVH
`define DGD_DEFINES_SVH

// register indices; the byte address is four times the index
`define DGD_IDX_TX_GAIN      8'h37
`define DGD_IDX_RX_GAIN      8'h38
`define DGD_IDX_DBL_CTRL     8'h39
`define DGD_IDX_TX_TUNE      8'h3a
`define DGD_IDX_RX_TUNE      8'h3b
`define DGD_IDX_TAP_DELAY    8'h3c
`define DGD_IDX_SIGN_INV     8'h3d
`define DGD_IDX_PULSE_WIDTH  8'h3e

// apb byte address width
`define DGD_ADDR_W           10

// doubler control/status fields
`define DGD_RX_RST_BIT       7
`define DGD_TX_RST_BIT       6
`define DGD_RX_LOCK_BIT      3
`define DGD_TX_LOCK_BIT      2
`define DGD_RX_SEL_BIT       1
`define DGD_TX_SEL_BIT       0

// tuning register fields
`define DGD_UNLOCK_HI        7
`define DGD_UNLOCK_LO        6
`define DGD_LOCK_HI          5
`define DGD_LOCK_LO          4
`define DGD_DLYOFS_HI        3
`define DGD_DLYOFS_LO        2
`define DGD_HYST_HI          1
`define DGD_HYST_LO          0

// sign inversion fields
`define DGD_RX_Q_NEGATE_BIT      3
`define DGD_RX_I_NEGATE_BIT      2
`define DGD_TX_Q_NEGATE_BIT      1
`define DGD_TX_I_NEGATE_BIT      0

// pulse width fields
`define DGD_TX_PW_HI         5
`define DGD_TX_PW_LO         3
`define DGD_RX_PW_HI         2
`define DGD_RX_PW_LO         0

// reset values
`define DGD_RST_TX_GAIN      5'h10
`define DGD_RST_RX_GAIN      5'h04
`define DGD_RST_DBL_CTRL     8'h00
`define DGD_RST_TUNE         8'h55
`define DGD_RST_TAP_DELAY    8'h02
`define DGD_RST_SIGN_INV     4'h0
`define DGD_RST_PULSE_WIDTH  6'h00

// gain code fraction bits
`define DGD_TX_FRAC          4
`define DGD_RX_FRAC          2

`endif

// ==== src/dgd_pkg.sv ====
// types shared by the gain and doubler register bank
package dgd_pkg;

    typedef enum logic [3:0] {
        DGD_REG_TX_GAIN,
        DGD_REG_RX_GAIN,
        DGD_REG_DBL_CTRL,
        DGD_REG_TX_TUNE,
        DGD_REG_RX_TUNE,
        DGD_REG_TAP_DELAY,
        DGD_REG_SIGN_INV,
        DGD_REG_PULSE_WIDTH,
        DGD_REG_NONE
    } dgd_reg_t;

    typedef enum logic [1:0] {
        DGD_CH_TX_I,
        DGD_CH_TX_Q,
        DGD_CH_RX_I,
        DGD_CH_RX_Q
    } dgd_chan_t;

endpackage : dgd_pkg

// ==== src/dgd_regs.sv ====
// gain, sign inversion and clock doubler control register bank with apb slave
//
// How it works
// - tx gain code/16 scales both tx channels
// - rx gain code/4 scales both rx channels
// - rx doubler reset bit resets rx doubler
// - tx doubler reset bit resets tx doubler
// - rx doubler lock readable as status bit
// - tx doubler lock readable as status bit
// - type select: 0 pulse width, 1 duty
// - per doubler 2-bit unlock count field
// - per doubler 2-bit lock count field
// - per doubler 2-bit delay line offset
// - per doubler 2-bit delay line hysteresis
// - shared 8-bit start tap delay field
// - rx q negate bit negates q samples
// - rx i negate bit negates i samples
// - tx q negate bit negates q samples
// - tx i negate bit negates i samples
// - tx doubler pulse width in bits 5:3
// - rx doubler pulse width in bits 2:0
`timescale 1ns/1ps
`include "dgd_defines.svh"

module dgd_regs
    import dgd_pkg::*;
#(
    parameter int DW = 12
) (
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  reset_i,
    // apb slave
    input  wire logic                  psel_i,
    input  wire logic                  penable_i,
    input  wire logic                  pwrite_i,
    input  wire logic [`DGD_ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]           pwdata_i,
    input  wire logic [3:0]            pstrb_i,
    output logic      [31:0]           prdata_o,
    output logic                       pready_o,
    output logic                       pslverr_o,
    // transmit samples in, after second interpolation stage
    input  wire logic                  tx_valid_i,
    input  wire logic signed [DW-1:0]  tx_i_i,
    input  wire logic signed [DW-1:0]  tx_q_i,
    // transmit samples out, toward the converters
    output logic                       tx_valid_o,
    output logic signed [DW-1:0]       tx_i_o,
    output logic signed [DW-1:0]       tx_q_o,
    // receive samples in, after the decimation filter
    input  wire logic                  rx_valid_i,
    input  wire logic signed [DW-1:0]  rx_i_i,
    input  wire logic signed [DW-1:0]  rx_q_i,
    // receive samples out
    output logic                       rx_valid_o,
    output logic signed [DW-1:0]       rx_i_o,
    output logic signed [DW-1:0]       rx_q_o,
    // lock indications from the doublers (asynchronous)
    input  wire logic                  rx_doubler_locked_i,
    input  wire logic                  tx_doubler_locked_i,
    // receive doubler controls
    output logic                       rx_doubler_reset_o,
    output logic                       rx_doubler_type_select_o,
    output logic [1:0]                 rx_unlock_count_o,
    output logic [1:0]                 rx_lock_count_o,
    output logic [1:0]                 rx_delay_line_offset_o,
    output logic [1:0]                 rx_delay_line_hysteresis_o,
    output logic [2:0]                 rx_doubler_pulse_width_o,
    // transmit doubler controls
    output logic                       tx_doubler_reset_o,
    output logic                       tx_doubler_type_select_o,
    output logic [1:0]                 tx_unlock_count_o,
    output logic [1:0]                 tx_lock_count_o,
    output logic [1:0]                 tx_delay_line_offset_o,
    output logic [1:0]                 tx_delay_line_hysteresis_o,
    output logic [2:0]                 tx_doubler_pulse_width_o,
    // shared doubler control
    output logic [7:0]                 doubler_start_tap_delay_o
);

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    generate
        if (DW < 4 || DW > 24) begin : g_bad_dw
            $error("dgd_regs: DW must lie in 4..24");
        end
    endgenerate

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // maps a byte address to a register; misaligned or unknown gives none
    function automatic dgd_reg_t dgd_decode(input logic [`DGD_ADDR_W-1:0] a);
        logic [7:0] idx;
        idx = a[`DGD_ADDR_W-1:2];
        if (a[1:0] != 2'h0) begin
            return DGD_REG_NONE;
        end
        case (idx)
            `DGD_IDX_TX_GAIN:     return DGD_REG_TX_GAIN;
            `DGD_IDX_RX_GAIN:     return DGD_REG_RX_GAIN;
            `DGD_IDX_DBL_CTRL:    return DGD_REG_DBL_CTRL;
            `DGD_IDX_TX_TUNE:     return DGD_REG_TX_TUNE;
            `DGD_IDX_RX_TUNE:     return DGD_REG_RX_TUNE;
            `DGD_IDX_TAP_DELAY:   return DGD_REG_TAP_DELAY;
            `DGD_IDX_SIGN_INV:    return DGD_REG_SIGN_INV;
            `DGD_IDX_PULSE_WIDTH: return DGD_REG_PULSE_WIDTH;
            default:              return DGD_REG_NONE;
        endcase
    endfunction : dgd_decode

    // negate, multiply by the gain code, drop fraction bits, saturate
    function automatic logic signed [DW-1:0] dgd_scale(
        input logic signed [DW-1:0] s,
        input logic                 neg,
        input logic [4:0]           g,
        input logic                 rx
    );
        logic signed [DW:0]   n;
        logic signed [DW+6:0] p;
        logic signed [DW+6:0] q;
        logic signed [DW+6:0] smax;
        logic signed [DW+6:0] smin;
        smax = $signed({8'h00, {(DW-1){1'b1}}});
        smin = $signed({8'hff, {(DW-1){1'b0}}});
        n = neg ? -$signed({s[DW-1], s}) : $signed({s[DW-1], s});
        p = n * $signed({1'b0, g});
        q = rx ? (p >>> `DGD_RX_FRAC) : (p >>> `DGD_TX_FRAC);
        if (q > smax) begin
            return smax[DW-1:0];
        end else if (q < smin) begin
            return smin[DW-1:0];
        end
        return q[DW-1:0];
    endfunction : dgd_scale

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    localparam logic [7:0] DBL_CTRL_RST = `DGD_RST_DBL_CTRL;

    logic [4:0] tx_stage1_gain_code_r;
    logic [4:0] rx_decim_gain_code_r;
    logic       rx_doubler_reset_r;
    logic       tx_doubler_reset_r;
    logic       rx_doubler_type_select_r;
    logic       tx_doubler_type_select_r;
    logic [7:0] tx_tune_r;
    logic [7:0] rx_tune_r;
    logic [7:0] doubler_start_tap_delay_r;
    logic [3:0] sign_inv_r;
    logic [5:0] pulse_width_r;

    // lock synchronisers
    logic [1:0] lock_meta_r;
    logic [1:0] lock_sync_r;

    // bus decode
    dgd_reg_t   sel_reg;
    logic       wr_en;
    logic       rd_en;
    logic [7:0] wbyte;
    logic [7:0] rd_val;

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    assign sel_reg  = dgd_decode(paddr_i);
    assign wr_en    = psel_i && penable_i && pwrite_i && (sel_reg != DGD_REG_NONE);
    // read data is captured in the setup cycle so it stands through the access phase
    assign rd_en    = psel_i && !penable_i && !pwrite_i;
    assign wbyte    = pstrb_i[0] ? pwdata_i[7:0] : 8'h00;
    assign pready_o = 1'b1;

    always_comb begin
        rd_val = 8'h00;
        case (sel_reg)
            DGD_REG_TX_GAIN:     rd_val = {3'h0, tx_stage1_gain_code_r};
            DGD_REG_RX_GAIN:     rd_val = {3'h0, rx_decim_gain_code_r};
            DGD_REG_DBL_CTRL: begin
                rd_val[`DGD_RX_RST_BIT]  = rx_doubler_reset_r;
                rd_val[`DGD_TX_RST_BIT]  = tx_doubler_reset_r;
                rd_val[`DGD_RX_LOCK_BIT] = lock_sync_r[1];
                rd_val[`DGD_TX_LOCK_BIT] = lock_sync_r[0];
                rd_val[`DGD_RX_SEL_BIT]  = rx_doubler_type_select_r;
                rd_val[`DGD_TX_SEL_BIT]  = tx_doubler_type_select_r;
            end
            DGD_REG_TX_TUNE:     rd_val = tx_tune_r;
            DGD_REG_RX_TUNE:     rd_val = rx_tune_r;
            DGD_REG_TAP_DELAY:   rd_val = doubler_start_tap_delay_r;
            DGD_REG_SIGN_INV:    rd_val = {4'h0, sign_inv_r};
            DGD_REG_PULSE_WIDTH: rd_val = {2'h0, pulse_width_r};
            default:             rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata_o <= {24'h00_0000, rd_val};
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pslverr_o <= 1'b0;
        end else begin
            pslverr_o <= psel_i && !penable_i && (dgd_decode(paddr_i) == DGD_REG_NONE);
        end
    end

    // ------------------------------------------------------------
    // gain registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            tx_stage1_gain_code_r <= `DGD_RST_TX_GAIN;
        end else if (wr_en && sel_reg == DGD_REG_TX_GAIN && pstrb_i[0]) begin
            tx_stage1_gain_code_r <= wbyte[4:0];
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rx_decim_gain_code_r <= `DGD_RST_RX_GAIN;
        end else if (wr_en && sel_reg == DGD_REG_RX_GAIN && pstrb_i[0]) begin
            rx_decim_gain_code_r <= wbyte[4:0];
        end
    end

    // ------------------------------------------------------------
    // doubler control; lock bits are never written
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rx_doubler_reset_r       <= DBL_CTRL_RST[`DGD_RX_RST_BIT];
            tx_doubler_reset_r       <= DBL_CTRL_RST[`DGD_TX_RST_BIT];
            rx_doubler_type_select_r <= DBL_CTRL_RST[`DGD_RX_SEL_BIT];
            tx_doubler_type_select_r <= DBL_CTRL_RST[`DGD_TX_SEL_BIT];
        end else if (wr_en && sel_reg == DGD_REG_DBL_CTRL && pstrb_i[0]) begin
            rx_doubler_reset_r       <= wbyte[`DGD_RX_RST_BIT];
            tx_doubler_reset_r       <= wbyte[`DGD_TX_RST_BIT];
            rx_doubler_type_select_r <= wbyte[`DGD_RX_SEL_BIT];
            tx_doubler_type_select_r <= wbyte[`DGD_TX_SEL_BIT];
        end
    end

    // lock inputs come from the doubler clocks, two flops before use
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            lock_meta_r <= 2'h0;
            lock_sync_r <= 2'h0;
        end else begin
            lock_meta_r <= {rx_doubler_locked_i, tx_doubler_locked_i};
            lock_sync_r <= lock_meta_r;
        end
    end

    // ------------------------------------------------------------
    // doubler tuning and sign inversion
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            tx_tune_r <= `DGD_RST_TUNE;
        end else if (wr_en && sel_reg == DGD_REG_TX_TUNE && pstrb_i[0]) begin
            tx_tune_r <= wbyte;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rx_tune_r <= `DGD_RST_TUNE;
        end else if (wr_en && sel_reg == DGD_REG_RX_TUNE && pstrb_i[0]) begin
            rx_tune_r <= wbyte;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            doubler_start_tap_delay_r <= `DGD_RST_TAP_DELAY;
        end else if (wr_en && sel_reg == DGD_REG_TAP_DELAY && pstrb_i[0]) begin
            doubler_start_tap_delay_r <= wbyte;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pulse_width_r <= `DGD_RST_PULSE_WIDTH;
        end else if (wr_en && sel_reg == DGD_REG_PULSE_WIDTH && pstrb_i[0]) begin
            pulse_width_r <= wbyte[5:0];
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            sign_inv_r <= `DGD_RST_SIGN_INV;
        end else if (wr_en && sel_reg == DGD_REG_SIGN_INV && pstrb_i[0]) begin
            sign_inv_r <= wbyte[3:0];
        end
    end

    // ------------------------------------------------------------
    // doubler outputs
    // ------------------------------------------------------------
    assign rx_doubler_reset_o         = rx_doubler_reset_r;
    assign tx_doubler_reset_o         = tx_doubler_reset_r;
    assign rx_doubler_type_select_o   = rx_doubler_type_select_r;
    assign tx_doubler_type_select_o   = tx_doubler_type_select_r;
    assign rx_unlock_count_o          = rx_tune_r[`DGD_UNLOCK_HI:`DGD_UNLOCK_LO];
    assign rx_lock_count_o            = rx_tune_r[`DGD_LOCK_HI:`DGD_LOCK_LO];
    assign rx_delay_line_offset_o     = rx_tune_r[`DGD_DLYOFS_HI:`DGD_DLYOFS_LO];
    assign rx_delay_line_hysteresis_o = rx_tune_r[`DGD_HYST_HI:`DGD_HYST_LO];
    assign tx_unlock_count_o          = tx_tune_r[`DGD_UNLOCK_HI:`DGD_UNLOCK_LO];
    assign tx_lock_count_o            = tx_tune_r[`DGD_LOCK_HI:`DGD_LOCK_LO];
    assign tx_delay_line_offset_o     = tx_tune_r[`DGD_DLYOFS_HI:`DGD_DLYOFS_LO];
    assign tx_delay_line_hysteresis_o = tx_tune_r[`DGD_HYST_HI:`DGD_HYST_LO];
    assign tx_doubler_pulse_width_o   = pulse_width_r[`DGD_TX_PW_HI:`DGD_TX_PW_LO];
    assign rx_doubler_pulse_width_o   = pulse_width_r[`DGD_RX_PW_HI:`DGD_RX_PW_LO];
    assign doubler_start_tap_delay_o  = doubler_start_tap_delay_r;

    // ------------------------------------------------------------
    // sample paths: one registered stage per channel
    // ------------------------------------------------------------
    logic signed [DW-1:0] smp_in  [4];
    logic signed [DW-1:0] smp_out [4];
    logic                 smp_neg [4];
    logic [4:0]           smp_gain[4];
    logic                 smp_rx  [4];

    assign smp_in[DGD_CH_TX_I]   = tx_i_i;
    assign smp_in[DGD_CH_TX_Q]   = tx_q_i;
    assign smp_in[DGD_CH_RX_I]   = rx_i_i;
    assign smp_in[DGD_CH_RX_Q]   = rx_q_i;
    assign smp_neg[DGD_CH_TX_I]  = sign_inv_r[`DGD_TX_I_NEGATE_BIT];
    assign smp_neg[DGD_CH_TX_Q]  = sign_inv_r[`DGD_TX_Q_NEGATE_BIT];
    assign smp_neg[DGD_CH_RX_I]  = sign_inv_r[`DGD_RX_I_NEGATE_BIT];
    assign smp_neg[DGD_CH_RX_Q]  = sign_inv_r[`DGD_RX_Q_NEGATE_BIT];
    assign smp_gain[DGD_CH_TX_I] = tx_stage1_gain_code_r;
    assign smp_gain[DGD_CH_TX_Q] = tx_stage1_gain_code_r;
    assign smp_gain[DGD_CH_RX_I] = rx_decim_gain_code_r;
    assign smp_gain[DGD_CH_RX_Q] = rx_decim_gain_code_r;
    assign smp_rx[DGD_CH_TX_I]   = 1'b0;
    assign smp_rx[DGD_CH_TX_Q]   = 1'b0;
    assign smp_rx[DGD_CH_RX_I]   = 1'b1;
    assign smp_rx[DGD_CH_RX_Q]   = 1'b1;

    generate
        for (genvar c = 0; c < 4; c++) begin : g_chan
            logic take;
            assign take = (c < 2) ? tx_valid_i : rx_valid_i;
            always_ff @(posedge clk_i or posedge reset_i) begin
                if (reset_i) begin
                    smp_out[c] <= '0;
                end else if (take) begin
                    smp_out[c] <= dgd_scale(smp_in[c], smp_neg[c], smp_gain[c], smp_rx[c]);
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            tx_valid_o <= 1'b0;
            rx_valid_o <= 1'b0;
        end else begin
            tx_valid_o <= tx_valid_i;
            rx_valid_o <= rx_valid_i;
        end
    end

    assign tx_i_o = smp_out[DGD_CH_TX_I];
    assign tx_q_o = smp_out[DGD_CH_TX_Q];
    assign rx_i_o = smp_out[DGD_CH_RX_I];
    assign rx_q_o = smp_out[DGD_CH_RX_Q];

endmodule : dgd_regs

// ==== testbench/dgd_regs_checker.sv ====
// assertion checker for the gain and doubler register bank
`timescale 1ns/1ps
module dgd_regs_checker #(
    parameter int DW = 12
) (
    // clock, reset and apb
    input wire logic                  clk_i,
    input wire logic                  reset_i,
    input wire logic                  psel_i,
    input wire logic                  penable_i,
    input wire logic                  pwrite_i,
    input wire logic [9:0]            paddr_i,
    input wire logic [31:0]           pwdata_i,
    input wire logic [3:0]            pstrb_i,
    input wire logic [31:0]           prdata_o,
    // samples
    input wire logic                  tx_valid_i,
    input wire logic                  tx_valid_o,
    input wire logic signed [DW-1:0]  tx_i_o,
    input wire logic                  rx_valid_i,
    input wire logic                  rx_valid_o,
    // doublers
    input wire logic                  rx_doubler_locked_i,
    input wire logic                  tx_doubler_locked_i,
    input wire logic                  rx_doubler_reset_o,
    input wire logic                  tx_doubler_reset_o,
    input wire logic [2:0]            rx_doubler_pulse_width_o,
    input wire logic [2:0]            tx_doubler_pulse_width_o,
    input wire logic [7:0]            doubler_start_tap_delay_o
);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    wire logic wr = psel_i && penable_i && pwrite_i && pstrb_i[0];
    wire logic rd = psel_i && penable_i && !pwrite_i;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    a_tx_valid_lag: assert property (tx_valid_i |=> tx_valid_o)
        else $error("tx valid not delayed by one cycle");
    a_tx_hold_idle: assert property (!tx_valid_i |=> $stable(tx_i_o))
        else $error("tx output moved without a sample");
    a_rx_valid_lag: assert property (rx_valid_i |=> rx_valid_o)
        else $error("rx valid not delayed by one cycle");
    a_rx_rst_write: assert property (wr && paddr_i == 10'h0e4 |=>
        rx_doubler_reset_o == $past(pwdata_i[7])) else $error("rx doubler reset wrong");
    a_tx_rst_write: assert property (wr && paddr_i == 10'h0e4 |=>
        tx_doubler_reset_o == $past(pwdata_i[6])) else $error("tx doubler reset wrong");
    a_rx_lock_read: assert property ((rx_doubler_locked_i [*4] ##0 rd &&
        paddr_i == 10'h0e4) |=> prdata_o[3]) else $error("rx lock status not read");
    a_tx_lock_read: assert property ((!tx_doubler_locked_i [*4] ##0 rd &&
        paddr_i == 10'h0e4) |=> !prdata_o[2]) else $error("tx lock status wrong");
    a_pulse_width_write: assert property (wr && paddr_i == 10'h0f8 |=>
        {tx_doubler_pulse_width_o, rx_doubler_pulse_width_o} == $past(pwdata_i[5:0]))
        else $error("pulse width fields wrong");
    a_tap_delay_write: assert property (wr && paddr_i == 10'h0f0 |=>
        doubler_start_tap_delay_o == $past(pwdata_i[7:0])) else $error("tap delay wrong");

    cover property (wr && paddr_i == 10'h0e4);
    cover property (tx_valid_i ##1 tx_valid_o);
    cover property (rd && paddr_i == 10'h0e4 && rx_doubler_locked_i);
endmodule : dgd_regs_checker

bind dgd_regs dgd_regs_checker #(.DW(DW)) dgd_regs_checker_inst (.*);

// ==== testbench/testbench.sv ====
// self-checking testbench for the gain and doubler register bank
`timescale 1ns/1ps
module testbench;
    import dgd_pkg::*;
    // ------------------------------------------------------------
    // signals and design
    // ------------------------------------------------------------
    localparam int DW = 12;
    logic                  clk_i = 0, reset_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic [9:0]            paddr_i = '0;
    logic [31:0]           pwdata_i = '0, prdata_o, rd;
    logic [3:0]            pstrb_i = '0;
    logic                  pready_o, pslverr_o, err, tx_valid_o, rx_valid_o;
    logic                  tx_valid_i = 0, rx_valid_i = 0;
    logic                  rx_doubler_locked_i = 0, tx_doubler_locked_i = 0;
    logic signed [DW-1:0]  tx_i_i = 1000, tx_q_i = -2048, rx_i_i = 1000, rx_q_i = -2048;
    logic signed [DW-1:0]  tx_i_o, tx_q_o, rx_i_o, rx_q_o;
    logic                  rx_doubler_reset_o, rx_doubler_type_select_o;
    logic                  tx_doubler_reset_o, tx_doubler_type_select_o;
    logic [1:0]            rx_unlock_count_o, rx_lock_count_o;
    logic [1:0]            rx_delay_line_offset_o, rx_delay_line_hysteresis_o;
    logic [1:0]            tx_unlock_count_o, tx_lock_count_o;
    logic [1:0]            tx_delay_line_offset_o, tx_delay_line_hysteresis_o;
    logic [2:0]            rx_doubler_pulse_width_o, tx_doubler_pulse_width_o;
    logic [7:0]            doubler_start_tap_delay_o;
    int                    n_errors = 0, num_checks = 0;

    dgd_regs #(.DW(DW)) dgd_regs_inst (.*);

    always #50 clk_i = ~clk_i;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        pstrb_i <= 4'h1;
        @(posedge clk_i);
        penable_i <= 1;
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        err = pslverr_o;
        rd = prdata_o;
        psel_i <= 0;
        penable_i <= 0;
        // let the written register settle before callers look at outputs
        @(posedge clk_i);
    endtask : apb

    // scaled, negated and saturated sample as software expects it
    function automatic int model(input int x, input bit n, input int g, input int sh);
        int v;
        v = ((n ? -x : x) * g) >>> sh;
        if (v > 2 ** (DW - 1) - 1) v = 2 ** (DW - 1) - 1;
        if (v < -(2 ** (DW - 1))) v = -(2 ** (DW - 1));
        return v;
    endfunction : model

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_values;
        logic [7:0] rv[8] = '{8'h10, 8'h04, 8'h00, 8'h55, 8'h55, 8'h02, 8'h00, 8'h00};
        for (int k = 0; k < 8; k++) begin
            apb(0, 10'h0dc + 10'(4 * k), '0);
            check(rd, {24'h0, rv[k]});
        end
        apb(1, 10'h0fc, 32'hff);
        check({31'h0, err}, 32'h1);
        apb(0, 10'h0e4, '0);
        check(rd, 32'h0);
    endtask : t_reset_values

    task automatic t_control;
        logic [7:0] v[2] = '{8'h81, 8'h4e};
        for (int k = 0; k < 2; k++) begin
            apb(1, 10'h0e4, {24'h0, v[k]});
            check({rx_doubler_reset_o, tx_doubler_reset_o}, {v[k][7], v[k][6]});
            check({rx_doubler_type_select_o, tx_doubler_type_select_o}, v[k][1:0]);
            apb(0, 10'h0e4, '0);
            check(rd, {24'h0, v[k] & 8'hc3});
        end
        apb(1, 10'h0e8, 32'he4);
        check({tx_unlock_count_o, tx_lock_count_o}, 4'he);
        check({tx_delay_line_offset_o, tx_delay_line_hysteresis_o}, 4'h4);
        apb(1, 10'h0ec, 32'h1b);
        check({rx_unlock_count_o, rx_lock_count_o}, 4'h1);
        check({rx_delay_line_offset_o, rx_delay_line_hysteresis_o}, 4'hb);
        apb(1, 10'h0f0, 32'ha5);
        check(doubler_start_tap_delay_o, 8'ha5);
        apb(1, 10'h0f8, 32'hee);
        check(tx_doubler_pulse_width_o, 3'h5);
        check(rx_doubler_pulse_width_o, 3'h6);
        apb(0, 10'h0f8, '0);
        check(rd, 32'h2e);
    endtask : t_control

    task automatic t_lock;
        apb(1, 10'h0e4, 32'h0c);
        rx_doubler_locked_i <= 1;
        repeat (3) @(posedge clk_i);
        apb(0, 10'h0e4, '0);
        check(rd, 32'h08);
        rx_doubler_locked_i <= 0;
        tx_doubler_locked_i <= 1;
        repeat (3) @(posedge clk_i);
        apb(0, 10'h0e4, '0);
        check(rd, 32'h04);
    endtask : t_lock

    task automatic t_samples;
        int g[5] = '{0, 1, 16, 31, 16};
        for (int k = 0; k < 5; k++) begin
            apb(1, 10'h0dc, 32'(g[k]));
            apb(1, 10'h0e0, 32'(g[k]));
            apb(1, 10'h0f4, 32'(k % 4 * 5));
            @(posedge clk_i);
            tx_valid_i <= 1;
            rx_valid_i <= 1;
            @(posedge clk_i);
            tx_valid_i <= 0;
            rx_valid_i <= 0;
            @(negedge clk_i);
            check({tx_valid_o, rx_valid_o}, 2'b11);
            check(32'(tx_i_o), model(1000, k[0], g[k], 4));
            check(32'(tx_q_o), model(-2048, k[1], g[k], 4));
            check(32'(rx_i_o), model(1000, k[0], g[k], 2));
            check(32'(rx_q_o), model(-2048, k[1], g[k], 2));
        end
    endtask : t_samples

    initial begin
        repeat (6) @(posedge clk_i);
        reset_i <= 0;
        t_reset_values();
        t_control();
        t_lock();
        t_samples();
        tally_and_finish();
    end

    initial begin
        #1_000_000;
        n_errors++;
        tally_and_finish();
    end
endmodule : testbench
